//--- src/cebr_pkg.sv
`default_nettype none
package cebr_pkg;
  localparam int               WORD_W = 18;
  localparam int               LANE_W = 9;
  localparam int               ADDR_W = 16;
  localparam int               NPORT  = 2;
  localparam logic [4:0]       LANE_OFS = 5'h09;
  localparam int               SH_W1  = 4;
  localparam int               SH_W2  = 3;
  localparam int               SH_W4  = 2;
  localparam int               SH_W9  = 1;
  localparam logic [WORD_W-1:0] MASK_W1  = 18'h00001;
  localparam logic [WORD_W-1:0] MASK_W2  = 18'h00003;
  localparam logic [WORD_W-1:0] MASK_W4  = 18'h0000f;
  localparam logic [WORD_W-1:0] MASK_W9  = 18'h001ff;
  localparam logic [WORD_W-1:0] MASK_W18 = 18'h3ffff;
  // Pattern returned for a mixed-port read of a word being written
  localparam logic [WORD_W-1:0] RDW_DONTCARE = 18'h3ffff;

  typedef enum logic [1:0] {CEBR_SMALL, CEBR_MEDIUM, CEBR_LARGE} cebr_size_t;
  typedef enum logic [2:0] {CEBR_TDP, CEBR_SDP, CEBR_SP, CEBR_SP2, CEBR_ROM, CEBR_SHIFT} cebr_mode_t;
  typedef enum logic [2:0] {CEBR_W1, CEBR_W2, CEBR_W4, CEBR_W9, CEBR_W18} cebr_width_t;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } cebr_req_t;
endpackage : cebr_pkg
`default_nettype wire

//--- src/cebr_port_map.sv
`default_nettype none
module cebr_port_map
  import cebr_pkg::*;
#(
  parameter int IDX_W = 5
)(
  input  wire cebr_width_t       width,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [WORD_W-1:0] wdata,
  input  wire logic [WORD_W-1:0] cur,
  input  wire logic [WORD_W-1:0] rword,
  output logic [IDX_W-1:0]       idx,
  output logic [WORD_W-1:0]      mask,
  output logic [WORD_W-1:0]      merged,
  output logic [WORD_W-1:0]      wval,
  output logic [WORD_W-1:0]      rval
);
  logic [4:0]        base;
  logic [WORD_W-1:0] nmask;
  logic [ADDR_W-1:0] widx;

  // Narrow ports skip parity bits; x9 and x18 reach them
  always_comb
  begin
    base  = '0;
    nmask = '0;
    widx  = addr;
    unique case (width)
      CEBR_W1:
      begin
        base  = (addr[3] ? LANE_OFS : 5'h00) + {2'h0, addr[2:0]};
        nmask = MASK_W1;
        widx  = addr >> SH_W1;
      end
      CEBR_W2:
      begin
        base  = (addr[2] ? LANE_OFS : 5'h00) + {2'h0, addr[1:0], 1'b0};
        nmask = MASK_W2;
        widx  = addr >> SH_W2;
      end
      CEBR_W4:
      begin
        base  = (addr[1] ? LANE_OFS : 5'h00) + {2'h0, addr[0], 2'h0};
        nmask = MASK_W4;
        widx  = addr >> SH_W4;
      end
      CEBR_W9:
      begin
        base  = addr[0] ? LANE_OFS : 5'h00;
        nmask = MASK_W9;
        widx  = addr >> SH_W9;
      end
      CEBR_W18: nmask = MASK_W18;
      default:  nmask = '0; // Illegal width code moves no bits
    endcase
    idx    = widx[IDX_W-1:0];
    mask   = nmask << base;
    wval   = wdata & nmask;
    merged = (cur & ~mask) | ((wval << base) & mask);
    rval   = (rword >> base) & nmask;
  end
endmodule : cebr_port_map
`default_nettype wire

//--- src/cebr_out_stage.sv
`default_nettype none
module cebr_out_stage
  import cebr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clr,
  input  wire logic              bypass,
  input  wire logic              load,
  input  wire logic [WORD_W-1:0] din,
  output logic [WORD_W-1:0]      q
);
  typedef struct packed {
    logic [WORD_W-1:0] lat;
    logic [WORD_W-1:0] q;
  } cebr_ost_t;

  cebr_ost_t st_reg;
  cebr_ost_t st_next;

  // Bypass hands array data straight to q; otherwise one more stage
  always_comb
  begin
    st_next = st_reg;
    if (load)
      st_next.lat = din;
    if (bypass)
    begin
      if (load)
        st_next.q = din;
    end
    else
      st_next.q = st_reg.lat;
  end

  // Clear is asynchronous so q drops without waiting for an edge
  always_ff @(posedge clk or posedge clr)
  begin
    if (clr)
      st_reg <= '0;
    else if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q = st_reg.q;

  a_bypass_path: assert property (@(posedge clk) disable iff (!rst_n || clr)
    (bypass && load) |=> q == $past(din))
    else $error("bypassed read data not on q");
  a_pipe_path: assert property (@(posedge clk) disable iff (!rst_n || clr)
    (!bypass && load) |=> ##1 q == $past(din, 2))
    else $error("registered read data late or wrong");
  a_clear_now: assert property (@(posedge clk) disable iff (!rst_n)
    clr |-> q == '0)
    else $error("output clear not seen at once");
endmodule : cebr_out_stage
`default_nettype wire

//--- src/cebr_block_ram.sv
// Contract
// - Medium and large true dual-port take any mix of two reads or writes.
// - Simple dual-port reads while writing; same word gives old data or don't-care.
// - Single-port write shows written data on q, one stage later if registered.
// - All inputs registered except port 1 read address and enable in flow-through; internal write strobe timed from the clock.
// - Output registers optional; bypass feeds array data straight out.
// - Small/medium simple dual-port flow-through: read address on falling edge.
// - Input clear acts at once; output reflects it from the next edge.
// - Output clear acts at once and shows on q immediately.
// - Large block has no preload; small and medium load initial contents.
// - Medium block hosts two single-port memories, each in half capacity.
// - Dual-port modes allow different widths on the two ports.
// - Each data byte carries one extra stored parity bit.
// - Shift mode writes and reads the array on the falling edge; one stage per cycle.
`default_nettype none
module cebr_block_ram
  import cebr_pkg::*;
#(
  parameter cebr_size_t        SIZE        = CEBR_SMALL,
  parameter int                DEPTH       = 32,
  parameter logic              INIT_ENABLE = 1'b1,
  parameter logic [WORD_W-1:0] INIT_WORD   = 18'h00000,
  parameter int                SHIFT_LEN   = 32
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire cebr_mode_t       mode,
  input  wire cebr_width_t      width [NPORT],
  input  wire logic             rdw_old,
  input  wire logic             flow_thru,
  input  wire logic [NPORT-1:0] bypass,
  input  wire logic [NPORT-1:0] in_clr,
  input  wire logic [NPORT-1:0] out_clr,
  input  wire cebr_req_t        req [NPORT],
  output logic [WORD_W-1:0]     q [NPORT],
  output logic                  cfg_ready
);
  localparam int               IDX_W      = $clog2(DEPTH);
  localparam logic             INIT_ON    = INIT_ENABLE && (SIZE != CEBR_LARGE);
  localparam logic [IDX_W-1:0] LAST_WORD  = IDX_W'(DEPTH - 1);
  localparam logic [IDX_W-1:0] SHIFT_LAST = IDX_W'(SHIFT_LEN - 1);

  typedef struct packed {
    logic             ready;
    logic             init_run;
    logic [IDX_W-1:0] init_cnt;
    logic [IDX_W-1:0] ptr;
  } cebr_st_t;

  typedef struct packed {
    cebr_req_t req;
    logic      cleared;
  } cebr_in_t;

  typedef struct packed {
    logic [NPORT-1:0]             valid;
    logic [NPORT-1:0][WORD_W-1:0] data;
  } cebr_raw_t;

  localparam cebr_st_t ST_RESET   = '{ready: !INIT_ON, init_run: INIT_ON, init_cnt: '0, ptr: '0};
  localparam cebr_in_t IN_CLEARED = '{req: '0, cleared: 1'b1};

  logic [WORD_W-1:0] mem [DEPTH];
  cebr_st_t          st_reg;
  cebr_st_t          st_next;
  cebr_raw_t         raw_reg;
  cebr_raw_t         raw_next;
  cebr_mode_t        eff_mode;
  logic              flow_on;
  logic [NPORT-1:0]  wr;
  logic [NPORT-1:0]  rd;
  wire cebr_in_t     in_q  [NPORT];
  wire cebr_width_t  ew    [NPORT];
  wire [ADDR_W-1:0]  paddr [NPORT];
  wire [IDX_W-1:0]   midx  [NPORT];
  wire [IDX_W-1:0]   eidx  [NPORT];
  wire [WORD_W-1:0]  cur   [NPORT];
  wire [WORD_W-1:0]  rword [NPORT];
  wire [WORD_W-1:0]  mask  [NPORT];
  wire [WORD_W-1:0]  wword [NPORT];
  wire [WORD_W-1:0]  wval  [NPORT];
  wire [WORD_W-1:0]  rval  [NPORT];

  // Modes a block size lacks fall back to the nearest one it has
  always_comb
  begin
    eff_mode = mode;
    if (SIZE == CEBR_SMALL && mode == CEBR_TDP)
      eff_mode = CEBR_SDP;
    if (SIZE != CEBR_MEDIUM && mode == CEBR_SP2)
      eff_mode = CEBR_SP;
    if (SIZE == CEBR_LARGE && mode == CEBR_SHIFT)
      eff_mode = CEBR_SDP;
  end

  assign flow_on = flow_thru && (SIZE != CEBR_LARGE) && (eff_mode == CEBR_SDP) && bypass[1];

  // Which port may write or read in the current mode
  always_comb
  begin
    wr = '0;
    rd = '0;
    unique case (eff_mode)
      CEBR_TDP:
      begin
        wr = {in_q[1].req.we, in_q[0].req.we};
        rd = {in_q[1].req.re, in_q[0].req.re};
      end
      CEBR_SDP:
      begin
        wr[0] = in_q[0].req.we;
        rd[1] = flow_on ? (req[1].re && st_reg.ready) : in_q[1].req.re;
      end
      CEBR_SP:
      begin
        wr[0] = in_q[0].req.we;
        rd[0] = in_q[0].req.re | in_q[0].req.we;
      end
      CEBR_SP2:
      begin
        wr = {in_q[1].req.we, in_q[0].req.we};
        rd = {in_q[1].req.re | in_q[1].req.we, in_q[0].req.re | in_q[0].req.we};
      end
      CEBR_ROM:
      begin
        // Large block cannot preload, so ROM content is written by the user
        if (SIZE == CEBR_LARGE)
          wr = {in_q[1].req.we, in_q[0].req.we};
        rd = {in_q[1].req.re, in_q[0].req.re};
      end
      CEBR_SHIFT:
      begin
        wr[0] = in_q[0].req.we;
        rd[1] = in_q[0].req.we;
      end
      default:
      begin
        wr = '0;
        rd = '0;
      end
    endcase
  end

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    cebr_in_t in_reg;
    cebr_in_t in_next;

    // Requests are ignored until preload has finished
    always_comb
    begin
      in_next.req     = st_reg.ready ? req[p] : '0;
      in_next.cleared = 1'b0;
    end

    // Input register; its clear is asynchronous
    always_ff @(posedge clk or posedge in_clr[p])
    begin
      if (in_clr[p])
        in_reg <= IN_CLEARED;
      else if (!rst_n)
        in_reg <= '0;
      else
        in_reg <= in_next;
    end

    assign in_q[p]  = in_reg;
    assign ew[p]    = (eff_mode == CEBR_SHIFT) ? CEBR_W18 : width[p];
    assign paddr[p] = (flow_on && p == 1) ? req[p].addr : in_reg.req.addr;
    // Split mode pins each port to its own half of the array
    assign eidx[p]  = (eff_mode == CEBR_SHIFT) ? st_reg.ptr :
                      (eff_mode == CEBR_SP2) ? {1'(p), midx[p][IDX_W-2:0]} : midx[p];
    assign rword[p] = mem[eidx[p]];

    cebr_port_map #(
      .IDX_W (IDX_W)
    ) u_map (
      .width  (ew[p]),
      .addr   (paddr[p]),
      .wdata  (in_reg.req.wdata),
      .cur    (cur[p]),
      .rword  (rword[p]),
      .idx    (midx[p]),
      .mask   (mask[p]),
      .merged (wword[p]),
      .wval   (wval[p]),
      .rval   (rval[p])
    );

    cebr_out_stage u_out (
      .clk    (clk),
      .rst_n  (rst_n),
      .clr    (out_clr[p]),
      .bypass (bypass[p]),
      .load   (raw_reg.valid[p]),
      .din    (raw_reg.data[p]),
      .q      (q[p])
    );
  end

  // Two writes to one word merge, port 1 last
  assign cur[0] = rword[0];
  assign cur[1] = (wr[0] && eidx[0] == eidx[1]) ? wword[0] : rword[1];

  // Array read result; old data comes free from reading before the write
  always_comb
  begin
    raw_next = '0;
    for (int p = 0; p < NPORT; p++)
    begin
      raw_next.valid[p] = rd[p] | in_q[p].cleared;
      if (in_q[p].cleared)
        raw_next.data[p] = '0;
      else if ((eff_mode == CEBR_SP || eff_mode == CEBR_SP2) && wr[p])
        raw_next.data[p] = wval[p];
      else if (rd[p] && wr[1-p] && eidx[1-p] == eidx[p] && eff_mode != CEBR_SHIFT &&
               (!rdw_old || SIZE == CEBR_LARGE))
        raw_next.data[p] = RDW_DONTCARE;
      else
        raw_next.data[p] = rval[p];
    end
  end

  // Falling edge is the self-timed strobe, half a cycle after capture
  always_ff @(negedge clk)
  begin
    if (!rst_n)
      raw_reg <= '0;
    else
      raw_reg <= raw_next;
  end

  // Array writes; no reset term, but the preload after reset rewrites every word unless INIT_ON is off
  always_ff @(negedge clk)
  begin
    if (st_reg.init_run)
      mem[st_reg.init_cnt] <= INIT_WORD;
    else
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        if (wr[p])
          mem[eidx[p]] <= wword[p];
      end
    end
  end

  // Preload sequencer and shift pointer
  always_comb
  begin
    st_next = st_reg;
    if (st_reg.init_run)
    begin
      st_next.init_cnt = st_reg.init_cnt + 1'b1;
      if (st_reg.init_cnt == LAST_WORD)
      begin
        st_next.init_run = 1'b0;
        st_next.ready    = 1'b1;
      end
    end
    if (eff_mode == CEBR_SHIFT && wr[0])
      st_next.ptr = (st_reg.ptr == SHIFT_LAST) ? '0 : st_reg.ptr + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_reg <= ST_RESET;
    else
      st_reg <= st_next;
  end

  assign cfg_ready = st_reg.ready;

  a_tdp_two_writes: assert property (@(negedge clk) disable iff (!rst_n)
    (eff_mode == CEBR_TDP && &wr && eidx[0] != eidx[1]) |=>
      mem[$past(eidx[0])] == $past(wword[0]) && mem[$past(eidx[1])] == $past(wword[1]))
    else $error("dual write lost a word");
  a_rdw_old_data: assert property (@(negedge clk) disable iff (!rst_n)
    (eff_mode == CEBR_SDP && wr[0] && rd[1] && eidx[0] == eidx[1] && rdw_old &&
     SIZE != CEBR_LARGE && !in_q[1].cleared) |=> raw_reg.data[1] == $past(rval[1]))
    else $error("read during write not old data");
  a_rdw_dont_care: assert property (@(negedge clk) disable iff (!rst_n)
    (eff_mode == CEBR_SDP && wr[0] && rd[1] && eidx[0] == eidx[1] && !rdw_old &&
     !in_q[1].cleared) |=> raw_reg.data[1] == RDW_DONTCARE)
    else $error("read during write not don't-care");
  a_sp_thru_byp: assert property (@(negedge clk) disable iff (!rst_n || out_clr[0])
    (eff_mode == CEBR_SP && wr[0] && bypass[0]) |=> q[0] == $past(wval[0]))
    else $error("single-port write not on q");
  a_sp_thru_reg: assert property (@(negedge clk) disable iff (!rst_n || out_clr[0])
    (eff_mode == CEBR_SP && wr[0] && !bypass[0]) |=> ##1 q[0] == $past(wval[0], 2))
    else $error("registered single-port write late");
  a_write_lands: assert property (@(negedge clk) disable iff (!rst_n)
    (wr[0] && !(wr[1] && eidx[1] == eidx[0])) |=> mem[$past(eidx[0])] == $past(wword[0]))
    else $error("write not stored");
  a_flow_read: assert property (@(negedge clk) disable iff (!rst_n)
    (flow_on && req[1].re && cfg_ready && !wr[0]) |=>
      raw_reg.valid[1] && raw_reg.data[1] == $past(rval[1]))
    else $error("flow-through read missed");
  a_inclr_now: assert property (@(posedge clk) disable iff (!rst_n)
    in_clr[0] |-> in_q[0].cleared && !in_q[0].req.we)
    else $error("input clear not immediate");
  a_inclr_next: assert property (@(negedge clk) disable iff (!rst_n)
    in_q[1].cleared |=> raw_reg.valid[1] && raw_reg.data[1] == '0)
    else $error("input clear not seen next edge");
  a_no_large_init: assert property (@(posedge clk) disable iff (!rst_n)
    (SIZE == CEBR_LARGE) |-> !st_reg.init_run && cfg_ready)
    else $error("large block preloading");
  a_split_halves: assert property (@(negedge clk) disable iff (!rst_n)
    (eff_mode == CEBR_SP2) |-> !eidx[0][IDX_W-1] && eidx[1][IDX_W-1])
    else $error("split ports share a half");
  a_narrow_mask: assert property (@(negedge clk) disable iff (!rst_n)
    (ew[1] == CEBR_W1) |-> $onehot(mask[1]))
    else $error("x1 port touches more than one bit");
  a_parity_lane: assert property (@(negedge clk) disable iff (!rst_n)
    (ew[0] == CEBR_W9) |-> $countones(mask[0]) == LANE_W)
    else $error("x9 lane lacks parity bit");
  a_shift_step: assert property (@(posedge clk) disable iff (!rst_n)
    (eff_mode == CEBR_SHIFT && wr[0]) |=>
      st_reg.ptr == (($past(st_reg.ptr) == SHIFT_LAST) ? '0 : $past(st_reg.ptr) + 1'b1))
    else $error("shift pointer did not advance");
endmodule : cebr_block_ram
`default_nettype wire

//--- test/cebr_user_model.sv
`default_nettype none
module cebr_user_model
  import cebr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rom_lock,
  input  wire cebr_req_t  cmd [NPORT],
  output var  cebr_req_t  req [NPORT]
);
  logic lock_reg = 1'b0;

  // Once the contents are written the lock is sticky; nothing reopens writes
  always_ff @(posedge clk)
  begin
    if (rom_lock)
    begin
      lock_reg <= 1'b1;
    end
  end

  // Requests are held as levels for the whole cycle, never as a timed pulse
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      req[p]    = cmd[p];
      req[p].we = cmd[p].we & ~(rom_lock | lock_reg);
      // An idle port shows junk on its address and data, not the last value
      if (!cmd[p].we && !cmd[p].re)
      begin
        req[p].addr  = ~cmd[p].addr;
        req[p].wdata = ~cmd[p].wdata;
      end
    end
  end
endmodule : cebr_user_model
`default_nettype wire

//--- test/tb_cebr_block_ram.sv
`default_nettype none
module tb_cebr_block_ram
  import cebr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [WORD_W-1:0] INIT_VAL = 18'h15a5a;
  localparam int                SLEN     = 4;
  logic              clk = 1'b0;
  logic              rst_n;
  logic              rdw_old;
  logic              flow_thru;
  logic              rom_lock;
  logic              cfg_ready;
  logic [NPORT-1:0]  bypass;
  logic [NPORT-1:0]  in_clr;
  logic [NPORT-1:0]  out_clr;
  cebr_mode_t        mode;
  cebr_width_t       width [NPORT];
  cebr_req_t         cmd   [NPORT];
  cebr_req_t         req   [NPORT];
  logic [WORD_W-1:0] q     [NPORT];
  logic [WORD_W-1:0] mem   [32];
  logic [WORD_W-1:0] sv    [12];
  logic [WORD_W-1:0] d0;
  logic [WORD_W-1:0] d1;
  logic [15:0]       pat;
  logic [31:0]       seed = 32'h00000011;
  int                num_errors = 0;
  int                tests_run  = 0;
  int                n;

  // Half period of the 25 MHz clock
  always #20 clk = ~clk;

  cebr_user_model i_user (.clk(clk), .rom_lock(rom_lock), .cmd(cmd), .req(req));

  cebr_block_ram #(.SIZE(CEBR_MEDIUM), .DEPTH(32), .INIT_ENABLE(1'b1), .INIT_WORD(INIT_VAL), .SHIFT_LEN(SLEN)) i_dut (
    .clk(clk), .rst_n(rst_n), .mode(mode), .width(width), .rdw_old(rdw_old), .flow_thru(flow_thru),
    .bypass(bypass), .in_clr(in_clr), .out_clr(out_clr), .req(req), .q(q), .cfg_ready(cfg_ready));

  // Repeatable data source
  function automatic logic [WORD_W-1:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[WORD_W-1:0];
  endfunction : rnd

  function automatic cebr_req_t mk(input logic w, input logic r, input int a, input logic [WORD_W-1:0] d);
    return '{w, r, a[ADDR_W-1:0], d};
  endfunction : mk

  // Sixteen single-bit writes over an all-ones word leave both parity bits set
  function automatic logic [WORD_W-1:0] bits_word(input logic [15:0] p);
    return {1'b1, p[15:8], 1'b1, p[7:0]};
  endfunction : bits_word

  // Read of a word under write: old contents or the fixed junk pattern
  function automatic logic [WORD_W-1:0] rdw_exp(input logic old, input logic [WORD_W-1:0] prev);
    return old ? prev : RDW_DONTCARE;
  endfunction : rdw_exp

  task automatic chk(input string name, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One cycle of requests on both ports, changed only at the falling edge
  // Non-blocking, so logic sampling on that same falling edge still sees the old request
  task automatic step(input cebr_req_t c0, input cebr_req_t c1);
    cmd[0] <= c0;
    cmd[1] <= c1;
    @(negedge clk);
  endtask : step

  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  initial
  begin
    mode = CEBR_TDP;
    width[0] = CEBR_W18;
    width[1] = CEBR_W18;
    {rdw_old, flow_thru, rom_lock} = 3'b100;
    {bypass, in_clr, out_clr} = 6'h30;
    cmd[0] <= '0;
    cmd[1] <= '0;
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    chk("cfg_busy", {17'h00000, cfg_ready}, 18'h00000);
    rst_n = 1'b1;
    n = 0;
    while (cfg_ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
    begin
      num_errors++;
      end_of_test();
    end
    // Preloaded contents at both ends of the array
    step(mk(0, 1, 0, 0), mk(0, 1, 31, 0));
    step('0, '0);
    chk("preload_lo", q[0], INIT_VAL);
    chk("preload_hi", q[1], INIT_VAL);
    // Two writes per cycle, back to back, then a write paired with a read
    for (int i = 0; i < 8; i++)
    begin
      mem[i] = rnd();
      mem[i+8] = rnd();
      step(mk(1, 0, i, mem[i]), mk(1, 0, i + 8, mem[i+8]));
    end
    mem[16] = rnd();
    step(mk(1, 0, 16, mem[16]), mk(0, 1, 3, 0));
    step('0, '0);
    chk("tdp_wr_rd", q[1], mem[3]);
    // Crossed reads show that both ports see one store
    for (int i = 0; i < 8; i++)
    begin
      step(mk(0, 1, i + 8, 0), mk(0, 1, i, 0));
      step('0, '0);
      chk("tdp_rd0", q[0], mem[i+8]);
      chk("tdp_rd1", q[1], mem[i]);
    end
    // Read during write of the same word, both settings
    mode = CEBR_SDP;
    mem[20] = INIT_VAL;
    for (int o = 0; o < 2; o++)
    begin
      rdw_old = o[0];
      d0 = rnd();
      step(mk(1, 0, 20, d0), mk(0, 1, 20, 0));
      step('0, '0);
      chk("sdp_rdw", q[1], rdw_exp(rdw_old, mem[20]));
      mem[20] = d0;
    end
    step('0, mk(0, 1, 20, 0));
    step('0, '0);
    chk("sdp_after", q[1], mem[20]);
    // Single port write-through, bypassed then registered
    mode = CEBR_SP;
    d0 = rnd();
    step(mk(1, 0, 21, d0), '0);
    step('0, '0);
    chk("sp_thru", q[0], d0);
    bypass[0] = 1'b0;
    d0 = rnd();
    d1 = rnd();
    step(mk(1, 0, 22, d0), '0);
    step(mk(1, 0, 23, d1), '0);
    step('0, '0);
    chk("sp_reg1", q[0], d0);
    step('0, '0);
    chk("sp_reg2", q[0], d1);
    // Output clear is seen at once and holds while asserted
    out_clr[0] = 1'b1;
    #1 chk("oclr_now", q[0], '0);
    @(negedge clk);
    chk("oclr_hold", q[0], '0);
    out_clr[0] = 1'b0;
    // Input clear reaches the output only through a clock edge
    bypass[0] = 1'b1;
    d0 = rnd() | 18'h00001;
    step(mk(1, 0, 24, d0), '0);
    step('0, '0);
    in_clr <= 2'b11;
    #1 chk("iclr_wait", q[0], d0);
    @(negedge clk);
    @(negedge clk);
    chk("iclr_edge", q[0], '0);
    chk("iclr_edge1", q[1], '0);
    in_clr <= 2'b00;
    // Single bits written, whole word and one lane read back
    mode = CEBR_SDP;
    step(mk(1, 0, 5, 18'h3ffff), '0);
    step('0, '0);
    width[0] = CEBR_W1;
    pat = 16'(rnd());
    for (int k = 0; k < 16; k++)
      step(mk(1, 0, 80 + k, {17'h0, pat[k]}), '0);
    step('0, mk(0, 1, 5, 0));
    step('0, '0);
    chk("mix_w18", q[1], bits_word(pat));
    width[1] = CEBR_W9;
    step('0, mk(0, 1, 11, 0));
    step('0, '0);
    chk("mix_lane", q[1], {9'h000, 1'b1, pat[15:8]});
    // A nine-bit lane written on its own, then a single bit read back
    width[0] = CEBR_W9;
    d0 = rnd() & 18'h001ff;
    step(mk(1, 0, 13, d0), '0);
    step('0, mk(0, 1, 13, 0));
    step('0, '0);
    chk("lane_wr", q[1], d0);
    width[1] = CEBR_W1;
    n = int'(rnd() & 18'h0000f);
    step('0, mk(0, 1, 80 + n, 0));
    step('0, '0);
    chk("mix_bit", q[1], {17'h00000, pat[n]});
    // Flow-through read: address taken at the falling edge, output stage bypassed
    width[1] = CEBR_W18;
    flow_thru = 1'b1;
    step('0, mk(0, 1, 3, 0));
    step('0, '0);
    chk("flow_rd", q[1], mem[3]);
    flow_thru = 1'b0;
    // Two independent memories at one address
    mode = CEBR_SP2;
    width[0] = CEBR_W18;
    width[1] = CEBR_W18;
    d0 = rnd();
    d1 = rnd();
    step(mk(1, 0, 2, d0), mk(1, 0, 2, d1));
    step(mk(0, 1, 2, 0), mk(0, 1, 2, 0));
    step('0, '0);
    chk("sp2_p0", q[0], d0);
    chk("sp2_p1", q[1], d1);
    // Shift line: each push returns the word pushed SLEN cycles before
    mode = CEBR_SHIFT;
    for (int i = 0; i < 13; i++)
    begin
      // A push shows on q two falling edges after it is driven
      if (i > SLEN + 1)
        chk("shift_tap", q[1], sv[i-SLEN-2]);
      if (i < 12)
      begin
        sv[i] = rnd();
        step(mk(1, 0, 0, sv[i]), '0);
      end
    end
    // ROM use: medium block ignores writes; once locked the user side stops writing
    step('0, '0);
    mode = CEBR_ROM;
    step(mk(1, 0, 25, rnd()), '0);
    rom_lock = 1'b1;
    step('0, mk(1, 0, 26, rnd()));
    step(mk(0, 1, 25, 0), mk(0, 1, 26, 0));
    step('0, '0);
    chk("rom_p0", q[0], INIT_VAL);
    chk("rom_p1", q[1], INIT_VAL);
    end_of_test();
  end
endmodule : tb_cebr_block_ram
`default_nettype wire
